// [core/cccr_pkg.sv]
package cccr_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [5:0] IDX_RSVD_A      = 6'h07;
  localparam logic [5:0] IDX_RSVD_B      = 6'h08;
  localparam logic [5:0] IDX_CHANNEL0_CONFIG     = 6'h09;
  localparam logic [5:0] IDX_OFFSET_HIGH = 6'h0a;
  localparam logic [5:0] IDX_OFFSET_LOW  = 6'h0b;
  localparam logic [5:0] IDX_GAIN_HIGH   = 6'h0c;
  localparam logic [5:0] IDX_GAIN_LOW    = 6'h0d;
  localparam int         NUM_REGS        = 7;

  // Slots in the local word array, counted from the lowest index
  localparam logic [2:0] SLOT_RSVD_A      = 3'h0;
  localparam logic [2:0] SLOT_RSVD_B      = 3'h1;
  localparam logic [2:0] SLOT_CHANNEL0_CONFIG     = 3'h2;
  localparam logic [2:0] SLOT_OFFSET_HIGH = 3'h3;
  localparam logic [2:0] SLOT_OFFSET_LOW  = 3'h4;
  localparam logic [2:0] SLOT_GAIN_HIGH   = 3'h5;
  localparam logic [2:0] SLOT_GAIN_LOW    = 3'h6;

  // Writable bits per slot, slot 6 first; all other bits read zero
  localparam logic [NUM_REGS-1:0][15:0] REG_WMASK = {
    16'hff00, 16'hffff, 16'hff00, 16'hffff, 16'hffc7, 16'hff0f, 16'hffff};
  // Values after reset per slot, slot 6 first
  localparam logic [NUM_REGS-1:0][15:0] REG_RESET = {
    16'h0000, 16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  // Field positions
  localparam int SEL_LSB     = 0;
  localparam int SEL_MSB     = 1;
  localparam int LOW_BYTE_LSB = 8;
  localparam int LOW_BYTE_MSB = 15;

  // Calibration arithmetic: gain of 800000h is unity
  localparam int CAL_WIDTH   = 24;
  localparam int CAL_SHIFT   = 23;
  localparam int CAL_LATENCY = 3;

  typedef enum logic [1:0] {
    CCCR_IN_NORMAL,
    CCCR_IN_SHORTED,
    CCCR_IN_TEST_POS,
    CCCR_IN_TEST_NEG
  } cccr_mux_e;

endpackage

// [core/cccr_cal_path.sv]
`timescale 1ns/1ns
module cccr_cal_path (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // Raw sample in
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_data,
  // Calibration words
  input  wire logic [23:0] offset_corr,
  input  wire logic [23:0] gain_corr,
  // Corrected sample out
  output logic             res_valid,
  output logic [23:0]      res_data
);

  logic        [2:0]  valid_q;
  logic signed [24:0] diff_q;
  logic signed [49:0] prod_q;
  logic        [23:0] res_q;
  logic signed [24:0] diff_w;
  logic signed [24:0] gain_s_w;
  logic signed [49:0] prod_w;
  logic               fits_w;
  logic        [23:0] sat_w;

  //////////////////////////////////////////////////////////////////////////////
  // Subtract offset, then scale by gain; gain is unsigned so it gets a zero top bit
  assign diff_w   = $signed({raw_data[23], raw_data}) - $signed({offset_corr[23], offset_corr});
  assign gain_s_w = $signed({1'b0, gain_corr});
  assign prod_w   = diff_q * gain_s_w;
  // Truncating shift; clamp instead of wrapping when the gain pushes past full scale
  assign fits_w   = (prod_q[49:46] == 4'h0) || (prod_q[49:46] == 4'hf);
  assign sat_w    = fits_w ? prod_q[46:23] : (prod_q[49] ? 24'h800000 : 24'h7fffff);

  always_ff @(posedge mclk) begin
    if (srst) begin
      valid_q <= 3'h0;
      diff_q  <= 25'h0;
      prod_q  <= 50'h0;
      res_q   <= 24'h0;
    end else begin
      valid_q <= {valid_q[1:0], raw_valid};
      diff_q  <= diff_w;   // see R11
      prod_q  <= prod_w;   // see R11
      res_q   <= sat_w;    // see R11
    end
  end

  assign res_valid = valid_q[cccr_pkg::CAL_LATENCY-1];
  assign res_data  = res_q;

endmodule // cccr_cal_path

// [core/cccr_regs.sv]
//
// Contract
// R1: Two-bit input select at bits 1:0: normal pins, shorted, positive or negative test.
// R2: Config register at 09h resets to 0000h; bits 5:3 read zero.
// R3: Offset correction is 24-bit two's complement; bits 23:8 fill register 0Ah.
// R4: Offset bits 7:0 sit in 0Bh bits 15:8; its bits 7:0 read zero.
// R5: Both offset registers reset to 0000h, giving zero offset.
// R6: Gain correction is 24-bit unsigned below 2.0; bits 23:8 fill register 0Ch.
// R7: Upper gain register resets to 8000h.
// R8: Lower gain register at 0Dh resets to 0000h; its bits 7:0 read-only.
// R9: Host writes zeros to reserved 08h writable bits; bits 7:4 read zero.
// R10: Gain bits 7:0 sit in bits 15:8 of the lower gain register.
// R11: Subtract offset from each raw result, then scale by gain, 800000h unity.
`timescale 1ns/1ns
module cccr_regs (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        srst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Input multiplexer control
  output logic [1:0]       ch0_input_select,
  output logic             ch0_pins_connected,
  output logic             ch0_inputs_shorted,
  output logic             ch0_test_enable,
  output logic             ch0_test_negative,
  // Raw samples from the converter
  input  wire logic        raw_valid,
  input  wire logic [23:0] raw_data,
  // Corrected samples
  output logic             result_valid,
  output logic [23:0]      result_data
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [31:0]      prdata_q;
  logic [31:0]      prdata_d;
  logic             pready_q;
  logic             pready_d;
  logic             pslverr_q;
  logic             pslverr_d;
  logic             connected_q;
  logic             connected_d;
  logic             shorted_q;
  logic             shorted_d;
  logic             test_en_q;
  logic             test_en_d;
  logic             test_neg_q;
  logic             test_neg_d;

  logic             access_w;
  logic             complete_w;
  logic [5:0]       word_idx_w;
  logic             aligned_w;
  logic             in_range_w;
  logic             hit_w;
  logic [5:0]       slot_wide_w;
  logic [2:0]       slot_w;
  logic             wr_w;
  logic [15:0]      lane_mask_w;
  logic [15:0]      rd_word_w;

  localparam int NUM_W = 1;

  logic [NUM_W-1:0] unused_w;

  logic [cccr_pkg::NUM_REGS-1:0][15:0] words_w;

  logic [23:0]      offset_corr_w;
  logic [23:0]      gain_corr_w;
  cccr_pkg::cccr_mux_e sel_w;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode
  // Every transfer takes one wait state so that pready, pslverr and prdata
  // all come from flip-flops; the cost is one cycle per access.

  assign access_w    = psel & penable;
  assign complete_w  = access_w & pready_q;
  assign word_idx_w  = paddr[7:2];
  assign aligned_w   = (paddr[1:0] == 2'h0);
  assign in_range_w  = (word_idx_w >= cccr_pkg::IDX_RSVD_A) &&
                       (word_idx_w <= cccr_pkg::IDX_GAIN_LOW);
  assign hit_w       = aligned_w & in_range_w;
  assign slot_wide_w = word_idx_w - cccr_pkg::IDX_RSVD_A;
  assign slot_w      = slot_wide_w[2:0];

  // Writes land only at the edge where the master sees pready high
  assign wr_w        = complete_w & pwrite & hit_w;
  // Registers are 16 bits wide, so only byte lanes 0 and 1 matter
  assign lane_mask_w = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  assign unused_w    = pwdata[31] | pwdata[16] | pstrb[3] | pstrb[2];

  //////////////////////////////////////////////////////////////////////////////
  // Register words

  genvar gi;
  generate
    for (gi = 0; gi < cccr_pkg::NUM_REGS; gi++) begin : g_word
      logic [15:0] word_q;
      logic [15:0] word_d;
      logic        sel_slot_w;
      logic [15:0] wmask_w;

      assign sel_slot_w = wr_w && (slot_w == 3'(gi));
      // Read-only bits never take a write and so keep reading zero
      assign wmask_w    = lane_mask_w & cccr_pkg::REG_WMASK[gi];  // see R2 see R4 see R8 see R9
      assign word_d     = (word_q & ~wmask_w) | (pwdata[15:0] & wmask_w);

      always_ff @(posedge mclk) begin
        if (srst) begin
          word_q <= cccr_pkg::REG_RESET[gi];  // see R2 see R5 see R7 see R8
        end else if (sel_slot_w) begin
          word_q <= word_d;
        end
      end

      assign words_w[gi] = word_q & cccr_pkg::REG_WMASK[gi];
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read path and answer

  assign rd_word_w = words_w[slot_w];

  always_comb begin
    pready_d  = access_w & ~pready_q;
    pslverr_d = access_w & ~pready_q & ~hit_w;
    prdata_d  = 32'h0;
    if (access_w && !pready_q && !pwrite && hit_w) begin
      prdata_d = {16'h0, rd_word_w};
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Input multiplexer control

  assign sel_w = cccr_pkg::cccr_mux_e'(
    words_w[cccr_pkg::SLOT_CHANNEL0_CONFIG][cccr_pkg::SEL_MSB:cccr_pkg::SEL_LSB]);

  always_comb begin
    connected_d = 1'b0;
    shorted_d   = 1'b0;
    test_en_d   = 1'b0;
    test_neg_d  = 1'b0;
    unique case (sel_w)  // see R1
      cccr_pkg::CCCR_IN_NORMAL: begin
        connected_d = 1'b1;
      end
      cccr_pkg::CCCR_IN_SHORTED: begin
        shorted_d = 1'b1;
      end
      cccr_pkg::CCCR_IN_TEST_POS: begin
        test_en_d = 1'b1;
      end
      cccr_pkg::CCCR_IN_TEST_NEG: begin
        test_en_d  = 1'b1;
        test_neg_d = 1'b1;
      end
    endcase
  end

  // Decoded controls trail the select field by one cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      connected_q <= 1'b1;
      shorted_q   <= 1'b0;
      test_en_q   <= 1'b0;
      test_neg_q  <= 1'b0;
    end else begin
      connected_q <= connected_d;
      shorted_q   <= shorted_d;
      test_en_q   <= test_en_d;
      test_neg_q  <= test_neg_d;
    end
  end

  assign ch0_input_select   =
    words_w[cccr_pkg::SLOT_CHANNEL0_CONFIG][cccr_pkg::SEL_MSB:cccr_pkg::SEL_LSB];  // see R1
  assign ch0_pins_connected = connected_q;
  assign ch0_inputs_shorted = shorted_q;
  assign ch0_test_enable    = test_en_q;
  assign ch0_test_negative  = test_neg_q;

  //////////////////////////////////////////////////////////////////////////////
  // Calibration words assembled from high and low registers

  assign offset_corr_w = {words_w[cccr_pkg::SLOT_OFFSET_HIGH],  // see R3
                          words_w[cccr_pkg::SLOT_OFFSET_LOW]
                                 [cccr_pkg::LOW_BYTE_MSB:cccr_pkg::LOW_BYTE_LSB]};  // see R4
  assign gain_corr_w   = {words_w[cccr_pkg::SLOT_GAIN_HIGH],  // see R6
                          words_w[cccr_pkg::SLOT_GAIN_LOW]
                                 [cccr_pkg::LOW_BYTE_MSB:cccr_pkg::LOW_BYTE_LSB]};  // see R10

  //////////////////////////////////////////////////////////////////////////////
  // Correction pipeline
  // Calibration words may change while samples are in flight; each stage
  // uses whatever value stands when the sample passes it.

  cccr_cal_path u_cal_path (
    .mclk        (mclk),
    .srst        (srst),
    .raw_valid   (raw_valid),
    .raw_data    (raw_data),
    .offset_corr (offset_corr_w),  // see R11
    .gain_corr   (gain_corr_w),    // see R11
    .res_valid   (result_valid),
    .res_data    (result_data)
  );

endmodule // cccr_regs

// [testbench/cccr_regs_props.sv]
`timescale 1ns/1ns
module cccr_regs_chk (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        srst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // Input select and samples
  input wire logic [1:0]  ch0_input_select,
  input wire logic        ch0_pins_connected,
  input wire logic        ch0_inputs_shorted,
  input wire logic        ch0_test_enable,
  input wire logic        ch0_test_negative,
  input wire logic        raw_valid,
  input wire logic        result_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  wire       rd_done = psel && penable && pready && !pwrite;
  wire       wr_cfg  = psel && penable && pready && pwrite && paddr == 8'h24 && pstrb[0];
  wire [1:0] wsel    = pwdata[1:0];
  //////////////////////////////////////////////////////////////////////////////
  chk_pins_normal: assert property (ch0_pins_connected == ($past(ch0_input_select) == 2'h0))
    else $error("Pin connect flag wrong");
  chk_short_flag: assert property (ch0_inputs_shorted == ($past(ch0_input_select) == 2'h1))
    else $error("Short flag wrong");
  chk_test_flags: assert property ({ch0_test_enable, ch0_test_negative} ==
    {$past(ch0_input_select) >= 2'h2, $past(ch0_input_select) == 2'h3})
    else $error("Test signal flags wrong");
  chk_sel_write: assert property (wr_cfg |=> ch0_input_select == $past(wsel))
    else $error("Input select not updated");
  chk_cfg_ro: assert property (rd_done && paddr == 8'h24 |-> prdata[5:3] == 3'h0)
    else $error("Config read-only bits not zero");
  chk_offlow_ro: assert property (rd_done && paddr == 8'h2c |-> prdata[7:0] == 8'h00)
    else $error("Offset low byte not zero");
  chk_gainlow_ro: assert property (rd_done && paddr == 8'h34 |-> prdata[7:0] == 8'h00)
    else $error("Gain low byte not zero");
  chk_result_lat: assert property (raw_valid |-> ##3 result_valid)
    else $error("Result missing");
  chk_result_cause: assert property (result_valid |-> $past(raw_valid, 3))
    else $error("Result without sample");
endmodule // cccr_regs_chk

bind cccr_regs cccr_regs_chk i_cccr_regs_chk (.mclk, .srst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .ch0_input_select, .ch0_pins_connected,
  .ch0_inputs_shorted, .ch0_test_enable, .ch0_test_negative, .raw_valid, .result_valid);

// [testbench/cccr_host.sv]
`timescale 1ns/1ns
module cccr_host (
  // Clock
  input wire logic         mclk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic [3:0]       pstrb,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  // Request held until pready is sampled; no fixed latency assumed
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= {4{wr}};
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // cccr_host

// [testbench/cccr_regs_tb.sv]
`timescale 1ns/1ns
module cccr_regs_tb;
  logic        mclk, srst, raw_valid, psel, penable, pwrite, pready, pslverr, err;
  logic        pins, shorted, ten, tneg, result_valid;
  logic [1:0]  sel;
  logic [7:0]  paddr;
  logic [3:0]  pstrb;
  logic [23:0] raw_data, result_data;
  logic [31:0] pwdata, prdata, rd;
  int          n_fail = 0;
  int          checks_done = 0;
  logic [7:0]  addrs [7] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h34};
  logic [31:0] rstv  [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8000, 32'h0};
  logic [7:0]  wa    [4] = '{8'h28, 8'h2c, 8'h30, 8'h34};
  logic [31:0] wm    [4] = '{32'hffff, 32'hff00, 32'hffff, 32'hff00};

  cccr_regs i_cccr_regs (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .ch0_input_select(sel), .ch0_pins_connected(pins),
    .ch0_inputs_shorted(shorted), .ch0_test_enable(ten), .ch0_test_negative(tneg),
    .raw_valid, .raw_data, .result_valid, .result_data);
  cccr_host i_cccr_host (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr);

  initial mclk = 1'b0;
  always #2 mclk = ~mclk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("Checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_cccr_host.xfer(1'b1, a, d, rd, err);
    check("write error", err, 32'h0);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    i_cccr_host.xfer(1'b0, a, 32'h0, rd, err);
    check(what, rd, exp);
  endtask
  // Result lands three edges after the sample edge
  task automatic sample(input logic [23:0] raw, input logic [23:0] exp);
    @(posedge mclk);
    raw_valid <= 1'b1;
    raw_data  <= raw;
    @(posedge mclk);
    raw_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 check("result_valid", result_valid, 32'h1);
    check("result_data", result_data, exp);
  endtask
  function automatic logic [23:0] cal(input logic [23:0] raw, off, gain);
    longint p;
    p = ((longint'($signed(raw)) - longint'($signed(off))) * longint'(gain)) >>> 23;
    if (p > 64'sh7fffff) p = 64'sh7fffff;
    if (p < -64'sh800000) p = -64'sh800000;
    return p[23:0];
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    srst = 1'b1;
    raw_valid = 1'b0;
    raw_data = 24'h0;
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    foreach (addrs[i]) rd_chk("reset value", addrs[i], rstv[i]);
    sample(24'h923456, 24'h923456);
    $display("Test reset done");
    wr(8'h20, 32'h0);
    foreach (wa[i]) begin
      wr(wa[i], 32'hffff);
      rd_chk("write mask", wa[i], wm[i]);
    end
    wr(8'h24, 32'h3b);
    rd_chk("config", 8'h24, 32'h3);
    $display("Test masks done");
    for (int m = 0; m < 4; m++) begin
      wr(8'h24, m);
      @(posedge mclk);
      #1 check("select", {sel, pins, shorted, ten, tneg}, {m[1:0], m == 0, m == 1, m[1], m == 3});
    end
    $display("Test select done");
    wr(8'h28, 32'h0);
    wr(8'h2c, 32'h1000);
    wr(8'h30, 32'hc000);
    wr(8'h34, 32'h8000);
    sample(24'h100010, cal(24'h100010, 24'h000010, 24'hc00080));
    sample(24'hf00000, cal(24'hf00000, 24'h000010, 24'hc00080));
    $display("Test calibration done");
    rd_chk("unmapped data", 8'h40, 32'h0);
    check("unmapped error", err, 32'h1);
    $display("Test unmapped done");
    close_out();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    close_out();
  end
endmodule // cccr_regs_tb
